// *** rtl/dma_progress_map.vh ***
// Register offsets, field layouts and reset values for the channel progress block
`ifndef DMA_PROGRESS_MAP_VH
`define DMA_PROGRESS_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_SOURCE_BYTE_POINTER      6'h00
`define OFS_DESTINATION_BYTE_POINTER 6'h04
`define OFS_CELL_TRANSFER_SIZE       6'h08
`define OFS_CELL_PROGRESS_POINTER    6'h0C
`define OFS_MATCH_PATTERN_BYTE       6'h10
`define OFS_SOURCE_SIZE              6'h14
`define OFS_DESTINATION_SIZE         6'h18
`define OFS_CHANNEL_CONTROL          6'h1C
`define OFS_CHANNEL_STATUS           6'h20

// ----------------------------------------
// Field layouts
// ----------------------------------------
`define POINTER_MSB                  15
`define PATTERN_MSB                  7
`define CTRL_ENABLE_BIT              0
`define CTRL_PATTERN_MODE_BIT        1
`define STAT_CELL_DONE_BIT           0
`define STAT_BLOCK_DONE_BIT          1
`define STAT_PATTERN_HIT_BIT         2
`define STAT_BUSY_BIT                3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RESET_POINTER                16'h0000
`define RESET_PATTERN                8'h00
`define RESET_CONTROL                2'h0
`define READ_ZERO                    32'h0000_0000

`endif

// *** rtl/dma_channel_progress.v ***
// Progress pointers, cell size, block sizes and pattern match for one DMA channel
`timescale 1ns/1ps
`include "dma_progress_map.vh"

// Overview of operation
// - A 16-bit read-only source pointer holds the source byte offset now addressed, 0 to 65,535.
// - In pattern-detect mode the source pointer clears to zero when the pattern is detected.
// - The destination pointer sits in bits 15:0, cannot be written by software, and resets to zero.
// - Software sets a 16-bit cell size; a trigger on an idle, enabled channel opens a cell that closes after that many bytes.
// - A 16-bit read-only cell progress pointer counts bytes moved since the open cell began.
// - In pattern-detect mode the cell progress pointer also clears on a pattern match.
// - Bits above 15 of the pointer and size registers ignore writes and read as zero.
// - In pattern mode the transfer ends when the pattern byte is seen; other modes ignore it.
module dma_channel_progress (
	// Clock and reset
	input  wire        clk,
	input  wire        reset,
	// Register port
	input  wire [5:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_write,
	input  wire        reg_read,
	output reg  [31:0] reg_rdata,
	// Channel event inputs
	input  wire        cell_trigger,
	input  wire        source_byte_read,
	input  wire        dest_byte_written,
	input  wire [7:0]  moved_byte,
	// Channel status outputs
	output wire        cell_active,
	output reg         cell_done,
	output reg         block_done,
	output reg         pattern_hit
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	reg  [15:0] source_pointer_field;
	reg  [15:0] destination_pointer_field;
	reg  [15:0] cell_size_field;
	reg  [15:0] cell_progress_field;
	reg  [7:0]  pattern_byte_field;
	reg  [15:0] source_size_field;
	reg  [15:0] destination_size_field;
	reg  [1:0]  control;
	reg         busy;
	reg         sticky_cell_done;
	reg         sticky_block_done;
	reg         sticky_pattern_hit;

	// ----------------------------------------
	// Decode and next state
	// ----------------------------------------
	wire        channel_enable;
	wire        pattern_mode;
	wire        byte_matches;
	wire        match_now;
	wire        src_step;
	wire        dst_step;
	wire        step;
	wire        cell_open;
	wire        cell_end;
	wire        src_end;
	wire        dst_end;
	wire        write_control;
	wire        write_status;
	wire        clear_cell_done;
	wire        clear_block_done;
	wire        clear_pattern_hit;

	reg  [15:0] next_source_pointer;
	reg  [15:0] next_destination_pointer;
	reg  [15:0] next_cell_progress;
	reg         next_busy;
	reg         next_sticky_cell_done;
	reg         next_sticky_block_done;
	reg         next_sticky_pattern_hit;
	reg  [31:0] next_reg_rdata;
	reg  [31:0] control_word;
	reg  [31:0] status_word;

	assign channel_enable = control[`CTRL_ENABLE_BIT];
	assign pattern_mode   = control[`CTRL_PATTERN_MODE_BIT];
	assign cell_active    = busy;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Size of zero is treated as the full 65,536 span
	function wrap_hit;
		input [15:0] count;
		input [15:0] limit;
		begin
			wrap_hit = (count == (limit - 16'h0001));
		end
	endfunction

	function [15:0] bump;
		input [15:0] value;
		begin
			bump = value + 16'h0001;
		end
	endfunction

	// Every 16-bit field reads back with its upper half tied low
	function [31:0] widen16;
		input [15:0] field;
		begin
			widen16 = {16'h0000, field};
		end
	endfunction

	// ----------------------------------------
	// Byte movement
	// ----------------------------------------
	// Only bytes moved while a cell is open count toward progress
	assign src_step     = busy & source_byte_read;
	assign dst_step     = busy & dest_byte_written;
	assign step         = dst_step;
	assign byte_matches = (moved_byte == pattern_byte_field);
	assign match_now    = pattern_mode & dst_step & byte_matches;
	// A trigger that arrives while a cell is open is ignored
	assign cell_open    = ~busy & channel_enable & cell_trigger;

	assign cell_end = step & wrap_hit(cell_progress_field, cell_size_field);
	assign src_end  = src_step & wrap_hit(source_pointer_field, source_size_field);
	assign dst_end  = dst_step & wrap_hit(destination_pointer_field, destination_size_field);

	assign write_control = reg_write & (reg_addr == `OFS_CHANNEL_CONTROL);
	assign write_status  = reg_write & (reg_addr == `OFS_CHANNEL_STATUS);

	// ----------------------------------------
	// Pointer next state
	// ----------------------------------------
	// A pattern match and a size wrap both restart at byte zero
	always @* begin
		next_source_pointer      = source_pointer_field;
		next_destination_pointer = destination_pointer_field;
		next_cell_progress       = cell_progress_field;
		next_busy                = busy;
		if (match_now || src_end) begin
			next_source_pointer = `RESET_POINTER;
		end else if (src_step) begin
			next_source_pointer = bump(source_pointer_field);
		end
		if (match_now || dst_end) begin
			next_destination_pointer = `RESET_POINTER;
		end else if (dst_step) begin
			next_destination_pointer = bump(destination_pointer_field);
		end
		if (match_now || cell_end || cell_open) begin
			next_cell_progress = `RESET_POINTER;
		end else if (step) begin
			next_cell_progress = bump(cell_progress_field);
		end
		// Disabling the channel abandons the open cell
		if (!channel_enable || match_now || cell_end) begin
			next_busy = 1'b0;
		end else if (cell_open) begin
			next_busy = 1'b1;
		end
	end

	// ----------------------------------------
	// Pointer registers
	// ----------------------------------------
	always @(posedge clk) begin
		if (reset) begin
			source_pointer_field      <= `RESET_POINTER;
			destination_pointer_field <= `RESET_POINTER;
			cell_progress_field       <= `RESET_POINTER;
			busy                      <= 1'b0;
		end else begin
			source_pointer_field      <= next_source_pointer;
			destination_pointer_field <= next_destination_pointer;
			cell_progress_field       <= next_cell_progress;
			busy                      <= next_busy;
		end
	end

	// ----------------------------------------
	// Event pulses and sticky status
	// ----------------------------------------
	assign clear_cell_done   = write_status & reg_wdata[`STAT_CELL_DONE_BIT];
	assign clear_block_done  = write_status & reg_wdata[`STAT_BLOCK_DONE_BIT];
	assign clear_pattern_hit = write_status & reg_wdata[`STAT_PATTERN_HIT_BIT];

	// Set wins over a same-cycle write-one-to-clear, so no event is lost
	always @* begin
		next_sticky_cell_done   = sticky_cell_done & ~clear_cell_done;
		next_sticky_block_done  = sticky_block_done & ~clear_block_done;
		next_sticky_pattern_hit = sticky_pattern_hit & ~clear_pattern_hit;
		if (cell_end) begin
			next_sticky_cell_done = 1'b1;
		end
		if (src_end || dst_end) begin
			next_sticky_block_done = 1'b1;
		end
		if (match_now) begin
			next_sticky_pattern_hit = 1'b1;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			cell_done          <= 1'b0;
			block_done         <= 1'b0;
			pattern_hit        <= 1'b0;
			sticky_cell_done   <= 1'b0;
			sticky_block_done  <= 1'b0;
			sticky_pattern_hit <= 1'b0;
		end else begin
			cell_done          <= cell_end;
			block_done         <= src_end | dst_end;
			pattern_hit        <= match_now;
			sticky_cell_done   <= next_sticky_cell_done;
			sticky_block_done  <= next_sticky_block_done;
			sticky_pattern_hit <= next_sticky_pattern_hit;
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	// Pointer registers have no write path at all
	always @(posedge clk) begin
		if (reset) begin
			cell_size_field        <= `RESET_POINTER;
			pattern_byte_field     <= `RESET_PATTERN;
			source_size_field      <= `RESET_POINTER;
			destination_size_field <= `RESET_POINTER;
			control                <= `RESET_CONTROL;
		end else if (reg_write) begin
			if (reg_addr == `OFS_CELL_TRANSFER_SIZE) begin
				cell_size_field <= reg_wdata[`POINTER_MSB:0];
			end else if (reg_addr == `OFS_MATCH_PATTERN_BYTE) begin
				pattern_byte_field <= reg_wdata[`PATTERN_MSB:0];
			end else if (reg_addr == `OFS_SOURCE_SIZE) begin
				source_size_field <= reg_wdata[`POINTER_MSB:0];
			end else if (reg_addr == `OFS_DESTINATION_SIZE) begin
				destination_size_field <= reg_wdata[`POINTER_MSB:0];
			end else if (write_control) begin
				control <= reg_wdata[1:0];
			end
		end
	end

	// ----------------------------------------
	// Control and status words
	// ----------------------------------------
	// Unused bits of both words read as zero
	always @* begin
		control_word                         = `READ_ZERO;
		control_word[`CTRL_ENABLE_BIT]       = channel_enable;
		control_word[`CTRL_PATTERN_MODE_BIT] = pattern_mode;
	end

	always @* begin
		status_word                        = `READ_ZERO;
		status_word[`STAT_CELL_DONE_BIT]   = sticky_cell_done;
		status_word[`STAT_BLOCK_DONE_BIT]  = sticky_block_done;
		status_word[`STAT_PATTERN_HIT_BIT] = sticky_pattern_hit;
		status_word[`STAT_BUSY_BIT]        = busy;
	end

	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	// Read data stands for one cycle only, zero otherwise
	always @* begin
		next_reg_rdata = `READ_ZERO;
		if (reg_read) begin
			if (reg_addr == `OFS_SOURCE_BYTE_POINTER) begin
				next_reg_rdata = widen16(source_pointer_field);
			end else if (reg_addr == `OFS_DESTINATION_BYTE_POINTER) begin
				next_reg_rdata = widen16(destination_pointer_field);
			end else if (reg_addr == `OFS_CELL_TRANSFER_SIZE) begin
				next_reg_rdata = widen16(cell_size_field);
			end else if (reg_addr == `OFS_CELL_PROGRESS_POINTER) begin
				next_reg_rdata = widen16(cell_progress_field);
			end else if (reg_addr == `OFS_MATCH_PATTERN_BYTE) begin
				next_reg_rdata = {24'h000000, pattern_byte_field};
			end else if (reg_addr == `OFS_SOURCE_SIZE) begin
				next_reg_rdata = widen16(source_size_field);
			end else if (reg_addr == `OFS_DESTINATION_SIZE) begin
				next_reg_rdata = widen16(destination_size_field);
			end else if (reg_addr == `OFS_CHANNEL_CONTROL) begin
				next_reg_rdata = control_word;
			end else if (reg_addr == `OFS_CHANNEL_STATUS) begin
				next_reg_rdata = status_word;
			end
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			reg_rdata <= `READ_ZERO;
		end else begin
			reg_rdata <= next_reg_rdata;
		end
	end

endmodule // dma_channel_progress

// *** tb/dma_channel_progress_checker.sv ***
// Port timing checker for the channel progress block
`timescale 1ns/1ps
`include "dma_progress_map.vh"
module dma_channel_progress_checker (
	// Watched ports
	input wire        clk,
	input wire        reset,
	input wire [5:0]  reg_addr,
	input wire        reg_read,
	input wire [31:0] reg_rdata,
	input wire        source_byte_read,
	input wire        dest_byte_written,
	input wire        cell_active,
	input wire        cell_done,
	input wire        block_done,
	input wire        pattern_hit
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_rd(a); reg_read && reg_addr == a; endsequence
	sequence s_idle_byte; !cell_active && dest_byte_written; endsequence
	property p_rd_idle; !$past(reg_read) |-> reg_rdata == `READ_ZERO; endproperty
	property p_hi_zero; $past(reg_read) |-> reg_rdata[31:16] == 16'h0000; endproperty
	property p_pat; s_rd(`OFS_MATCH_PATTERN_BYTE) |=> reg_rdata[31:8] == 24'h000000; endproperty
	property p_done; cell_done |-> $past(dest_byte_written) && !cell_active; endproperty
	property p_done1; cell_done |=> !cell_done; endproperty
	property p_hit; pattern_hit |-> $past(dest_byte_written) && !cell_active; endproperty
	property p_blk; block_done |-> $past(source_byte_read || dest_byte_written); endproperty
	property p_quiet; s_idle_byte |=> !cell_done && !pattern_hit && !block_done; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
	a_hi_zero: assert property (p_hi_zero) else $error("upper bits set");
	a_pat: assert property (p_pat) else $error("pattern upper bits set");
	a_done: assert property (p_done) else $error("cell done without byte");
	a_done1: assert property (p_done1) else $error("cell done too long");
	a_hit: assert property (p_hit) else $error("hit without byte");
	a_blk: assert property (p_blk) else $error("block done without byte");
	a_quiet: assert property (p_quiet) else $error("idle byte counted");
endmodule // dma_channel_progress_checker
bind dma_channel_progress dma_channel_progress_checker chk (.clk(clk), .reset(reset), .reg_addr(reg_addr),
	.reg_read(reg_read), .reg_rdata(reg_rdata), .source_byte_read(source_byte_read),
	.dest_byte_written(dest_byte_written), .cell_active(cell_active), .cell_done(cell_done),
	.block_done(block_done), .pattern_hit(pattern_hit));

// *** tb/dma_channel_progress_bench.sv ***
// Self-checking bench for the channel progress block
`timescale 1ns/1ps
`include "dma_progress_map.vh"
module dma_channel_progress_bench;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic [5:0]  reg_addr = 6'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_write = 1'b0;
	logic        reg_read = 1'b0;
	logic        cell_trigger = 1'b0;
	logic        src_rd = 1'b0;
	logic        dst_wr = 1'b0;
	logic [7:0]  moved_byte = 8'h00;
	wire  [31:0] reg_rdata;
	wire         cell_active, cell_done, block_done, pattern_hit;
	int          err_count = 0, num_checks = 0, cycles = 0;
	always #2.5 clk = ~clk;
	dma_channel_progress uut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .cell_trigger(cell_trigger),
		.source_byte_read(src_rd), .dest_byte_written(dst_wr), .moved_byte(moved_byte),
		.cell_active(cell_active), .cell_done(cell_done), .block_done(block_done), .pattern_hit(pattern_hit));
	// ----------------------------------------
	// Bus and event tasks
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	task wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge clk) begin reg_write <= 1'b1; reg_addr <= a; reg_wdata <= d; end
		@(posedge clk) reg_write <= 1'b0;
	endtask
	task rd(input logic [5:0] a, input logic [31:0] e, input string m);
		@(posedge clk) begin reg_read <= 1'b1; reg_addr <= a; end
		@(posedge clk) reg_read <= 1'b0;
		#1 chk(reg_rdata, e, m);
	endtask
	// Moves one byte on both sides
	task mv(input logic [7:0] d);
		@(posedge clk) begin dst_wr <= 1'b1; src_rd <= 1'b1; moved_byte <= d; end
		@(posedge clk) begin dst_wr <= 1'b0; src_rd <= 1'b0; end
	endtask
	task trig;
		@(posedge clk) cell_trigger <= 1'b1;
		@(posedge clk) cell_trigger <= 1'b0;
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			final_report;
		end
	end
	task t_reset;
		for (int i = 0; i < 5; i++) rd(6'(i * 4), 32'h0, "reset value");
	endtask
	task t_access;
		wr(`OFS_CELL_TRANSFER_SIZE, 32'hFFFFFFFF);
		rd(`OFS_CELL_TRANSFER_SIZE, 32'h0000FFFF, "cell size");
		wr(`OFS_MATCH_PATTERN_BYTE, 32'hFFFFFFFF);
		rd(`OFS_MATCH_PATTERN_BYTE, 32'h000000FF, "pattern");
		wr(`OFS_DESTINATION_BYTE_POINTER, 32'h0000FFFF);
		rd(`OFS_DESTINATION_BYTE_POINTER, 32'h0, "dest ptr write");
		wr(`OFS_SOURCE_BYTE_POINTER, 32'h0000FFFF);
		rd(`OFS_SOURCE_BYTE_POINTER, 32'h0, "source ptr write");
		rd(6'h3C, 32'h0, "unmapped");
	endtask
	task t_cell;
		wr(`OFS_CELL_TRANSFER_SIZE, 32'h3);
		wr(`OFS_CHANNEL_CONTROL, 32'h1);
		trig;
		#1 chk(cell_active, 1, "cell open");
		mv(8'h00);
		mv(8'h00);
		trig;
		rd(`OFS_CELL_PROGRESS_POINTER, 32'h2, "progress");
		mv(8'h00);
		#1 chk(cell_done, 1, "cell done");
		rd(`OFS_SOURCE_BYTE_POINTER, 32'h3, "source ptr");
		mv(8'h00);
		rd(`OFS_DESTINATION_BYTE_POINTER, 32'h3, "dest ptr");
		rd(`OFS_CHANNEL_STATUS, 32'h1, "status cell done");
		wr(`OFS_CHANNEL_STATUS, 32'h7);
		rd(`OFS_CHANNEL_STATUS, 32'h0, "status cleared");
	endtask
	task t_pattern;
		wr(`OFS_MATCH_PATTERN_BYTE, 32'h5A);
		wr(`OFS_CHANNEL_CONTROL, 32'h3);
		trig;
		mv(8'h11);
		mv(8'h5A);
		#1 chk(pattern_hit, 1, "pattern hit");
		rd(`OFS_SOURCE_BYTE_POINTER, 32'h0, "source cleared");
		rd(`OFS_CELL_PROGRESS_POINTER, 32'h0, "progress cleared");
	endtask
	task t_block;
		wr(`OFS_DESTINATION_SIZE, 32'h2);
		wr(`OFS_SOURCE_SIZE, 32'h2);
		wr(`OFS_CELL_TRANSFER_SIZE, 32'h8);
		wr(`OFS_CHANNEL_CONTROL, 32'h1);
		trig;
		mv(8'h01);
		mv(8'h02);
		#1 chk(block_done, 1, "block done");
		rd(`OFS_DESTINATION_BYTE_POINTER, 32'h0, "dest wrap");
		rd(`OFS_SOURCE_BYTE_POINTER, 32'h0, "source wrap");
	endtask
	initial begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		t_reset;
		t_access;
		t_cell;
		t_pattern;
		t_block;
		final_report;
	end
endmodule // dma_channel_progress_bench
